// ---- common/cbc_pkg.sv ----
// Package of constants for the charger boot control block
package cbc_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ    = 4'h8;
   // ==========================================================
   // Control register field positions
   localparam int CTRL_SW_CHARGE    = 0;
   localparam int CTRL_VI_PROGRAM   = 1;
   localparam int CTRL_SW_OVERRIDE  = 2;
   localparam int CTRL_SW_SWITCH    = 3;
   localparam int CTRL_LPB_ACK      = 4;
   localparam int CTRL_THERM_DIS    = 5;
   localparam int CTRL_GP_OUTPUT_ONE_EN      = 6;
   localparam int CTRL_TRICKLE_EN   = 7;
   localparam int CTRL_CUR_LSB      = 8;
   localparam int CTRL_W            = 12;
   localparam logic [11:0] CTRL_RESET = 12'h080;
   // ==========================================================
   // Status register field positions
   localparam int ST_LPB     = 0;
   localparam int ST_FACTORY = 1;
   localparam int ST_OUTTEMP = 2;
   localparam int ST_CHG_ON  = 3;
   localparam int ST_INT_LOW = 4;
   localparam int ST_SERIAL  = 5;
   localparam int ST_W       = 6;
   // ==========================================================
   // Charge current codes
   localparam logic [3:0] CUR_LPB_START = 4'h1;
   localparam logic [3:0] CUR_LPB_STEP  = 4'h4;
   localparam logic [3:0] CUR_MIN_500   = 4'h6;
   localparam logic [3:0] CUR_PRE_560   = 4'h7;
   localparam logic [3:0] CUR_PRE_400   = 4'h5;
   localparam logic [3:0] CUR_ZERO      = 4'h0;
   localparam logic [3:0] CUR_FULL_ON   = 4'hF;
   // ==========================================================
   // Boot sequencer states
   typedef enum logic [2:0] {
      BOOT_OFF, BOOT_POWERUP, BOOT_WATCHDOG, BOOT_ON, BOOT_TRICKLE
   } cbc_boot_e;
endpackage

// ---- src/cbc_sync.sv ----
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module cbc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- src/cbc_top.sv ----
// Charger boot control: software charge, factory mode, low-power boot, thermistor
// Summary of operation
// - Software-charge bit hands charger settings to software; safety paths stay autonomous.
// - System reset asserting returns charging to standalone operation.
// - In software mode switch follows control bit only when override set.
// - Supply below power-on while switch open closes switch if battery above minimum.
// - Factory mode is USB supply present with ID line pulled high.
// - Factory serial path: pass devices full on, switch open, trickle off, timers off.
// - Factory single path: 500 mA minimum, precharge timers run, charge timer off.
// - Factory mode allows V/I programming; software-charge bit ends factory mode.
// - Strap grounded means normal boot; strap high permits low-power boot.
// - Low-power-boot status set only when USB, low supply, strap, serial all hold.
// - Normal boot with grounded strap: turn on with charger input, supply above power-on or battery above battery-on, else trickle.
// - Not qualified with strap high: interrupt held low through cold-start watchdog.
// - Low-power boot starts at code 0001, USB supplies on, LED off; then 0100.
// - Low-power boot drives interrupt high before watchdog, holds other interrupts off.
// - Watchdog low or reset during boot: power down, trickle recovery, status cleared.
// - Once serial active software clears boot interrupt; On mode restores normal interrupts.
// - Acknowledge bit enables trickle and LED; switch closes above battery minimum.
// - Supply above power-on exits trickle, clears status, raises boot interrupt.
// - Charger present and core ready: drive output one high, check thermistor.
// - Thermistor out of range: wait with timers paused and no battery current.
// - Out-of-temperature current and switch states depend on the charging configuration.
// - Thermistor disable bypasses check and output drive; cold die still forces fault.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cbc_top
   import cbc_pkg::*;
(
   // Clock and reset
   input  wire logic         CLK_I,
   input  wire logic         SYS_RST_I,
   // Wishbone slave
   input  wire logic         CYC_I,
   input  wire logic         STB_I,
   input  wire logic         WE_I,
   input  wire logic [3:0]   ADR_I,
   input  wire logic [3:0]   SEL_I,
   input  wire logic [31:0]  DAT_I,
   output logic      [31:0]  DAT_O,
   output logic              ACK_O,
   // Analog comparators and pins (asynchronous)
   input  wire logic         USB_SUPPLY_I,
   input  wire logic         CHARGER_INPUT_I,
   input  wire logic         USB_ID_LINE_I,
   input  wire logic         APP_SUPPLY_ON_THRESH_I,
   input  wire logic         BATT_MIN_THRESH_I,
   input  wire logic         BATT_ON_THRESH_I,
   input  wire logic         THERMISTOR_IN_RANGE_I,
   input  wire logic         DIE_COLD_I,
   input  wire logic         MODE_STRAP_I,
   input  wire logic         SERIAL_PATH_I,
   input  wire logic         CORE_READY_I,
   input  wire logic         SYSTEM_RESET_N_I,
   input  wire logic         WATCHDOG_INPUT_I,
   input  wire logic         POWERUP_DONE_I,
   input  wire logic         OVERVOLT_I,
   input  wire logic         PASS_OVERHEAT_I,
   // Charger controls
   output logic              BATT_SWITCH_O,
   output logic [3:0]        CHARGE_CURRENT_CODE_O,
   output logic              TRICKLE_EN_O,
   output logic              CHARGE_LED_O,
   output logic              CHARGE_TIMER_EN_O,
   output logic              PRECHARGE_TIMER_EN_O,
   output logic              POWER_LIMITER_EN_O,
   output logic              CHARGE_VI_PROGRAM_EN_O,
   output logic              USB_SUPPLIES_EN_O,
   output logic              GP_OUTPUT_ONE_O,
   output logic              POWER_TREE_EN_O,
   // Host side
   output logic              INT_O,
   output logic              PROCESSOR_RESET_N_O
);
   // ==========================================================
   // Input synchronisation
   localparam int NS = 16;
   logic [NS-1:0] s;
   cbc_sync #(.W(NS)) u_sync (
      .clk_i (CLK_I),
      .rst_i (SYS_RST_I),
      .d_i   ({POWERUP_DONE_I, PASS_OVERHEAT_I, OVERVOLT_I, WATCHDOG_INPUT_I,
                SYSTEM_RESET_N_I, CORE_READY_I, SERIAL_PATH_I, MODE_STRAP_I,
                DIE_COLD_I, THERMISTOR_IN_RANGE_I, BATT_ON_THRESH_I,
                BATT_MIN_THRESH_I, APP_SUPPLY_ON_THRESH_I, USB_ID_LINE_I,
                CHARGER_INPUT_I, USB_SUPPLY_I}),
      .q_o   (s)
   );
   logic usb, chg, usb_id_line, bp_ok, bmin, bon, th_ok, cold, strap, serial;
   logic core, sysrst_n, watchdog_input, ovp, ovh, pu_done;
   assign {pu_done, ovh, ovp, watchdog_input, sysrst_n, core, serial, strap, cold, th_ok,
           bon, bmin, bp_ok, usb_id_line, chg, usb} = s;

   // ==========================================================
   // Register file
   logic [CTRL_W-1:0] ctrl;
   logic [ST_W-1:0]   status;
   logic              irq_q, irq_clr, sysrst_n_q;
   cbc_wb_regs u_regs (
      .clk_i           (CLK_I),
      .rst_i           (SYS_RST_I),
      .cyc_i           (CYC_I),
      .stb_i           (STB_I),
      .we_i            (WE_I),
      .adr_i           (ADR_I),
      .sel_i           (SEL_I),
      .dat_i           (DAT_I),
      .dat_o           (DAT_O),
      .ack_o           (ACK_O),
      .clr_sw_charge_i (sysrst_n_q & ~sysrst_n),
      .status_i        (status),
      .irq_flag_i      (irq_q),
      .irq_clr_o       (irq_clr),
      .ctrl_o          (ctrl)
   );
   logic sw_charge_ctrl, charge_vi_program_en, batt_switch_override, batt_switch_ctrl;
   logic low_power_boot_ack, thermistor_check_disable, gp_output_one_en, sw_trickle;
   logic [3:0] sw_current;
   assign sw_charge_ctrl           = ctrl[CTRL_SW_CHARGE];
   assign charge_vi_program_en     = ctrl[CTRL_VI_PROGRAM];
   assign batt_switch_override     = ctrl[CTRL_SW_OVERRIDE];
   assign batt_switch_ctrl         = ctrl[CTRL_SW_SWITCH];
   assign low_power_boot_ack       = ctrl[CTRL_LPB_ACK];
   assign thermistor_check_disable = ctrl[CTRL_THERM_DIS];
   assign gp_output_one_en         = ctrl[CTRL_GP_OUTPUT_ONE_EN];
   assign sw_trickle               = ctrl[CTRL_TRICKLE_EN];
   assign sw_current               = ctrl[CTRL_CUR_LSB +: 4];

   // ==========================================================
   // Factory mode detection and exit
   logic factory_q;
   logic usb_q;
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         factory_q <= 1'b0;
         usb_q     <= 1'b0;
      end else begin
         usb_q <= usb;
         if (!usb || sw_charge_ctrl) factory_q <= 1'b0;
         else if (usb && !usb_q && usb_id_line) factory_q <= 1'b1;
      end
   end

   // ==========================================================
   // Low-power boot qualification and sequencer
   cbc_boot_e boot_q;
   logic lpb_q, cold_start_q, int_low_q, trickle_rec_q;
   logic lpb_qual;
   assign lpb_qual = usb & ~factory_q & ~bp_ok & strap & serial;

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         boot_q        <= BOOT_OFF;
         sysrst_n_q    <= 1'b0;
         lpb_q         <= 1'b0;
         cold_start_q  <= 1'b1;
         trickle_rec_q <= 1'b0;
      end else begin
         sysrst_n_q <= sysrst_n;
         case (boot_q)
            BOOT_OFF: begin
               if (usb || chg) begin
                  lpb_q <= lpb_qual;
                  if (lpb_qual || bp_ok || bon || chg) boot_q <= BOOT_POWERUP;
                  else boot_q <= BOOT_TRICKLE;
               end
            end
            BOOT_POWERUP: if (pu_done) boot_q <= BOOT_WATCHDOG;
            BOOT_WATCHDOG: begin
               if (!watchdog_input || (lpb_q && !sysrst_n)) begin
                  boot_q        <= BOOT_TRICKLE;
                  lpb_q         <= 1'b0;
                  trickle_rec_q <= 1'b1;
               end else if (sysrst_n) begin
                  boot_q       <= BOOT_ON;
                  cold_start_q <= 1'b0;
               end
            end
            BOOT_ON: begin
               if (lpb_q && (!watchdog_input || !sysrst_n)) begin
                  boot_q        <= BOOT_TRICKLE;
                  lpb_q         <= 1'b0;
                  trickle_rec_q <= 1'b1;
               end else if (lpb_q && bp_ok) lpb_q <= 1'b0;
            end
            BOOT_TRICKLE: begin
               if (!usb && !chg) boot_q <= BOOT_OFF;
               else if (bon && !trickle_rec_q) boot_q <= BOOT_POWERUP;
               else if (bp_ok) begin
                  trickle_rec_q <= 1'b0;
                  boot_q        <= BOOT_POWERUP;
               end
            end
            default: boot_q <= BOOT_OFF;
         endcase
      end
   end

   // Boot interrupt flag: falling status sets it, set wins over clear
   logic lpb_d1_q;
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         lpb_d1_q <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         lpb_d1_q <= lpb_q;
         if (lpb_d1_q && !lpb_q) irq_q <= 1'b1;
         else if (irq_clr) irq_q <= 1'b0;
      end
   end

   // ==========================================================
   // Thermistor check
   logic out_temp;
   assign out_temp = cold | (~thermistor_check_disable & chg & core & ~th_ok);

   // ==========================================================
   // Charger control outputs
   logic       sw_q;
   logic [3:0] cur_d;
   always_comb begin
      cur_d = CUR_MIN_500;
      if (factory_q) cur_d = serial ? CUR_FULL_ON : CUR_MIN_500;
      else if (lpb_q) cur_d = (boot_q == BOOT_POWERUP && !pu_done) ? CUR_LPB_START
                                                        : CUR_LPB_STEP;
      if (charge_vi_program_en && (factory_q || !lpb_q)) cur_d = sw_current;
      if (sw_charge_ctrl) cur_d = sw_current;
      if (out_temp) begin
         if (lpb_q) cur_d = CUR_PRE_400;
         else if (chg && !bon) cur_d = charge_vi_program_en ? sw_current
                                                            : CUR_PRE_560;
         else cur_d = CUR_ZERO;
      end
      if (ovp || ovh || (!chg && !usb)) cur_d = CUR_ZERO;
   end

   // Battery switch
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) sw_q <= 1'b0;
      else if (sw_charge_ctrl && !bp_ok && bmin) sw_q <= 1'b1;
      else if (sw_charge_ctrl && batt_switch_override) sw_q <= batt_switch_ctrl;
      else if (factory_q && serial) sw_q <= 1'b0;
      else if (out_temp) sw_q <= ~((lpb_q || (chg && !bon)));
      else if (lpb_q) sw_q <= low_power_boot_ack & bmin;
      else sw_q <= bon;
   end

   // Registered outputs
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         CHARGE_CURRENT_CODE_O  <= 4'h0;
         TRICKLE_EN_O           <= 1'b0;
         CHARGE_LED_O           <= 1'b0;
         CHARGE_TIMER_EN_O      <= 1'b0;
         PRECHARGE_TIMER_EN_O   <= 1'b0;
         POWER_LIMITER_EN_O     <= 1'b0;
         CHARGE_VI_PROGRAM_EN_O <= 1'b0;
         USB_SUPPLIES_EN_O      <= 1'b0;
         GP_OUTPUT_ONE_O        <= 1'b0;
         POWER_TREE_EN_O        <= 1'b0;
         PROCESSOR_RESET_N_O    <= 1'b0;
         BATT_SWITCH_O          <= 1'b0;
      end else begin
         BATT_SWITCH_O         <= sw_q;
         CHARGE_CURRENT_CODE_O <= cur_d;
         TRICKLE_EN_O <= ~out_temp & ~(factory_q & serial)
                         & (lpb_q ? low_power_boot_ack
                            : (sw_charge_ctrl ? sw_trickle : serial));
         CHARGE_LED_O <= lpb_q ? low_power_boot_ack : (chg | usb);
         CHARGE_TIMER_EN_O    <= ~factory_q & ~out_temp;
         PRECHARGE_TIMER_EN_O <= ~(factory_q & serial) & ~out_temp;
         POWER_LIMITER_EN_O   <= ~factory_q;
         CHARGE_VI_PROGRAM_EN_O <= charge_vi_program_en | sw_charge_ctrl;
         USB_SUPPLIES_EN_O <= usb & (boot_q != BOOT_OFF) & (boot_q != BOOT_TRICKLE);
         GP_OUTPUT_ONE_O <= (chg & core & ~thermistor_check_disable) | gp_output_one_en;
         POWER_TREE_EN_O <= (boot_q == BOOT_POWERUP) || (boot_q == BOOT_WATCHDOG)
                            || (boot_q == BOOT_ON);
         PROCESSOR_RESET_N_O <= (boot_q == BOOT_WATCHDOG) || (boot_q == BOOT_ON);
      end
   end

   // Interrupt pin: forced before On state per boot flavour (low-power boot: power-up and watchdog phases)
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         INT_O     <= 1'b0;
         int_low_q <= 1'b0;
      end else begin
         int_low_q <= 1'b0;
         if (lpb_q && (boot_q == BOOT_POWERUP || boot_q == BOOT_WATCHDOG))
            INT_O <= 1'b1;
         else if (!lpb_q && strap && cold_start_q && boot_q != BOOT_ON) begin
            INT_O     <= 1'b0;
            int_low_q <= 1'b1;
         end else INT_O <= irq_q;
      end
   end

   // Status word
   assign status = {serial, int_low_q, sw_charge_ctrl, out_temp, factory_q, lpb_q};
endmodule
`default_nettype wire

// ---- src/cbc_wb_regs.sv ----
// Wishbone classic slave holding control and showing status
`timescale 1ns/1ps
`default_nettype none
module cbc_wb_regs
   import cbc_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [3:0]           adr_i,
   input  wire logic [3:0]           sel_i,
   input  wire logic [31:0]          dat_i,
   output logic      [31:0]          dat_o,
   output logic                      ack_o,
   // Block side
   input  wire logic                 clr_sw_charge_i,
   input  wire logic [ST_W-1:0]      status_i,
   input  wire logic                 irq_flag_i,
   output logic                      irq_clr_o,
   output logic      [CTRL_W-1:0]    ctrl_o
);
   logic req;
   logic wr_ctrl;
   assign req     = cyc_i & stb_i & ~ack_o;
   assign wr_ctrl = req & we_i & (adr_i == ADDR_CTRL);

   // One-wait-state acknowledge and read data
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (req && !we_i) begin
            case (adr_i)
               ADDR_CTRL:   dat_o <= {20'h0_0000, ctrl_o};
               ADDR_STATUS: dat_o <= {26'h000_0000, status_i};
               ADDR_IRQ:    dat_o <= {31'h0000_0000, irq_flag_i};
               default:     dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control register, byte lanes 0 and 1; reset forces back to standalone
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_o <= CTRL_RESET;
      end else begin
         if (wr_ctrl && sel_i[0]) ctrl_o[7:0] <= dat_i[7:0];
         if (wr_ctrl && sel_i[1]) ctrl_o[11:8] <= dat_i[11:8];
         if (clr_sw_charge_i) ctrl_o[CTRL_SW_CHARGE] <= 1'b0;
      end
   end

   // Write one to bit 0 of the interrupt register clears the flag
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) irq_clr_o <= 1'b0;
      else irq_clr_o <= req & we_i & sel_i[0] & dat_i[0] & (adr_i == ADDR_IRQ);
   end
endmodule
`default_nettype wire

// ---- testbench/cbc_bench.sv ----
// Self-checking bench for the block
`timescale 1ns/1ps
`default_nettype none
module cbc_bench;
   import cbc_pkg::*;
   logic        clk, rst, cyc, stb, we, ack, watchdog_input, ok;
   logic [3:0]  adr, sel, code;
   logic [31:0] wdat, rdat, d;
   logic        usb, chg, usb_id_line, app, bmin, bon, therm, cold, strap, ser, core, srn, pdone, ov, ph;
   logic        sw_o, trk, led, ctim, ptim, plim, vip, usbe, gpo, tree, int_o, prn;
   logic [7:0]  dly;
   int          mismatches, comparisons;
   cbc_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
      .USB_SUPPLY_I(usb), .CHARGER_INPUT_I(chg), .USB_ID_LINE_I(usb_id_line),
      .APP_SUPPLY_ON_THRESH_I(app), .BATT_MIN_THRESH_I(bmin), .BATT_ON_THRESH_I(bon),
      .THERMISTOR_IN_RANGE_I(therm), .DIE_COLD_I(cold), .MODE_STRAP_I(strap),
      .SERIAL_PATH_I(ser), .CORE_READY_I(core), .SYSTEM_RESET_N_I(srn),
      .WATCHDOG_INPUT_I(watchdog_input), .POWERUP_DONE_I(pdone), .OVERVOLT_I(ov), .PASS_OVERHEAT_I(ph),
      .BATT_SWITCH_O(sw_o), .CHARGE_CURRENT_CODE_O(code), .TRICKLE_EN_O(trk),
      .CHARGE_LED_O(led), .CHARGE_TIMER_EN_O(ctim), .PRECHARGE_TIMER_EN_O(ptim),
      .POWER_LIMITER_EN_O(plim), .CHARGE_VI_PROGRAM_EN_O(vip), .USB_SUPPLIES_EN_O(usbe),
      .GP_OUTPUT_ONE_O(gpo), .POWER_TREE_EN_O(tree), .INT_O(int_o), .PROCESSOR_RESET_N_O(prn));
   cbc_host_model u_host (.clk_i(clk), .rst_i(rst), .proc_rst_n_i(prn), .enum_ok_i(ok),
      .delay_i(dly), .wdi_o(watchdog_input));
   // Clock
   always #5 clk = ~clk;
   // Bus cycles held until ack
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      {cyc, stb, we, adr, sel, wdat} <= {3'h7, a, 4'hF, v};
      do @(posedge clk); while (ack !== 1'b1);
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      {cyc, stb, we, adr, sel} <= {3'h6, a, 4'hF};
      do @(posedge clk); while (ack !== 1'b1);
      v = rdat;
      {cyc, stb} <= 2'h0;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Pin changes settle within ten cycles
   task automatic settle();
      repeat (10) @(posedge clk);
   endtask
   task automatic reset_dut();
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang watchdog
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   // Test sequence
   initial begin
      {clk, rst, cyc, stb, we, adr, sel, wdat, mismatches, comparisons} = '0;
      rst = 1'b1;
      // usb chg uid app, bmin bon therm cold, strap ser core srn, pdone ov ph ok
      {usb, chg, usb_id_line, app, bmin, bon, therm, cold, strap, ser, core, srn, pdone, ov, ph, ok} =
         16'h5E71;
      dly = 8'h02;
      reset_dut();
      rd(ADDR_CTRL, d); chk("ctrl reset", d, {20'h0_0000, CTRL_RESET});
      rd(ADDR_IRQ, d); chk("irq reset", d, 32'h0000_0000);
      rd(4'hC, d); chk("unmapped", d, 32'h0000_0000);
      settle(); chk("gpo auto", gpo, 1'b1);
      wr(ADDR_CTRL, 32'h0000_008D); settle();
      chk("switch on", sw_o, 1'b1);
      rd(ADDR_STATUS, d); chk("sw mode", d[ST_CHG_ON], 1'b1);
      wr(ADDR_CTRL, 32'h0000_0085); settle();
      chk("switch off", sw_o, 1'b0);
      app <= 1'b0; settle();
      chk("switch closes", sw_o, 1'b1);
      app <= 1'b1; srn <= 1'b0; settle(); srn <= 1'b1; settle();
      rd(ADDR_CTRL, d); chk("sw cleared", d[CTRL_SW_CHARGE], 1'b0);
      $display("software charge done");
      reset_dut(); wr(ADDR_CTRL, 32'h0000_00A0); settle();
      chk("gpo inhibited", gpo, 1'b0);
      wr(ADDR_CTRL, 32'h0000_00E0); cold <= 1'b1; settle();
      chk("gpo enabled", gpo, 1'b1);
      rd(ADDR_STATUS, d); chk("cold die", d[ST_OUTTEMP], 1'b1);
      wr(ADDR_CTRL, 32'h0000_0080); cold <= 1'b0; therm <= 1'b0; settle();
      rd(ADDR_STATUS, d); chk("hot battery", d[ST_OUTTEMP], 1'b1);
      chk("timers paused", {ctim, ptim}, 2'h0);
      therm <= 1'b1; settle();
      rd(ADDR_STATUS, d); chk("back in range", d[ST_OUTTEMP], 1'b0);
      $display("thermistor done");
      for (int i = 0; i < 2; i++) begin
         usb <= 1'b0; usb_id_line <= 1'b1; ser <= (i == 0);
         reset_dut(); usb <= 1'b1; settle();
         rd(ADDR_STATUS, d); chk("factory", d[ST_FACTORY], 1'b1);
         if (i == 0) chk("factory serial", {sw_o, trk, ctim, ptim, plim}, 5'h00);
         else chk("factory single", {code, ptim, ctim, plim}, {CUR_MIN_500, 3'h4});
         wr(ADDR_CTRL, 32'h0000_0082); settle();
         chk("vi program", vip, 1'b1);
         wr(ADDR_CTRL, 32'h0000_0083); settle();
         rd(ADDR_STATUS, d); chk("factory exit", d[ST_FACTORY], 1'b0);
      end
      $display("factory done");
      for (int k = 0; k < 2; k++) begin
         usb <= 1'b0; usb_id_line <= 1'b0; ser <= 1'b1; app <= 1'b0; strap <= 1'b1; pdone <= 1'b0;
         ok <= (k == 0); dly <= (k == 0) ? 8'h02 : 8'h1E;
         reset_dut(); usb <= 1'b1; settle();
         rd(ADDR_STATUS, d); chk("boot status", d[ST_LPB], 1'b1);
         chk("boot start", {code, led, usbe}, {CUR_LPB_START, 2'h1});
         pdone <= 1'b1; do @(posedge clk); while (prn !== 1'b1);
         chk("boot step", {code, int_o, prn}, {CUR_LPB_STEP, 2'h3});
         repeat (40) @(posedge clk);
         chk("power tree", tree, (k == 0));
         rd(ADDR_STATUS, d); chk("boot kept", d[ST_LPB], (k == 0));
         if (k == 0) begin
            wr(ADDR_CTRL, 32'h0000_0090); settle();
            chk("ack trickle", {trk, led}, 2'h3);
            app <= 1'b1; settle();
            rd(ADDR_STATUS, d); chk("boot done", d[ST_LPB], 1'b0);
            rd(ADDR_IRQ, d); chk("boot irq", d[0], 1'b1);
            wr(ADDR_IRQ, 32'h0000_0001); rd(ADDR_IRQ, d); chk("irq clear", d[0], 1'b0);
         end
      end
      $display("low-power boot done");
      conclude();
   end
endmodule
`default_nettype wire

// ---- testbench/cbc_host_model.sv ----
// Host processor model for the watchdog line
`timescale 1ns/1ps
`default_nettype none
module cbc_host_model (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_i,
   // Processor side
   input wire logic       proc_rst_n_i,
   input wire logic       enum_ok_i,
   input wire logic [7:0] delay_i,
   output logic           wdi_o
);
   logic [7:0] cnt_q;
   // Enumeration outcome after a delay
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i || !proc_rst_n_i) begin
         cnt_q <= 8'h00;
         wdi_o <= 1'b1;
      end else if (cnt_q < delay_i) begin
         cnt_q <= cnt_q + 8'h01;
      end else begin
         wdi_o <= enum_ok_i;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/cbc_top_props.sv ----
// Port-level checker of the top
`timescale 1ns/1ps
`default_nettype none
module cbc_top_props (
   // Clock, reset and bus
   input wire logic        CLK_I,
   input wire logic        SYS_RST_I,
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic        WE_I,
   input wire logic [3:0]  ADR_I,
   input wire logic [3:0]  SEL_I,
   input wire logic [31:0] DAT_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   // Pins
   input wire logic        CHARGER_INPUT_I,
   input wire logic        CORE_READY_I,
   input wire logic        APP_SUPPLY_ON_THRESH_I,
   input wire logic        BATT_MIN_THRESH_I,
   input wire logic        THERMISTOR_IN_RANGE_I,
   input wire logic        DIE_COLD_I,
   input wire logic        SYSTEM_RESET_N_I,
   // Outputs
   input wire logic        BATT_SWITCH_O,
   input wire logic        GP_OUTPUT_ONE_O,
   input wire logic        CHARGE_TIMER_EN_O,
   input wire logic        PRECHARGE_TIMER_EN_O
);
   import cbc_pkg::*;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   logic       sw_q, ov_q, ct_q, td_q, ge_q;
   logic [6:0] pin_q;
   logic [3:0] settle_q;
   wire logic calm = settle_q == 4'h8;
   wire logic [6:0] pins = {CHARGER_INPUT_I, CORE_READY_I, APP_SUPPLY_ON_THRESH_I,
      BATT_MIN_THRESH_I, THERMISTOR_IN_RANGE_I, DIE_COLD_I, SYSTEM_RESET_N_I};
   wire logic ctrl_wr = ACK_O && CYC_I && STB_I && WE_I && ADR_I == ADDR_CTRL && SEL_I[0];
   // Mirror of written control bits
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         {sw_q, ov_q, ct_q, td_q, ge_q} <= 5'h0;
      end else if (ctrl_wr) begin
         {sw_q, ov_q, ct_q, td_q, ge_q} <= {DAT_I[CTRL_SW_CHARGE], DAT_I[CTRL_SW_OVERRIDE],
            DAT_I[CTRL_SW_SWITCH], DAT_I[CTRL_THERM_DIS], DAT_I[CTRL_GP_OUTPUT_ONE_EN]};
      end else if (!SYSTEM_RESET_N_I) begin
         sw_q <= 1'b0;
      end
   end
   // Cycles since last change
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         settle_q <= 4'h0;
      end else if (ctrl_wr || pins != pin_q) begin
         settle_q <= 4'h0;
      end else if (settle_q != 4'hF) begin
         settle_q <= settle_q + 4'h1;
      end
   end
   always_ff @(posedge CLK_I) begin
      pin_q <= pins;
   end
   // Bus handshake and rule checks
   a_ack_pulse: assert property (ACK_O |=> !ACK_O)
      else $error("ack longer than one cycle");
   a_ack_latency: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("ack not one cycle after request");
   a_unmapped_zero: assert property (ACK_O && !WE_I && ADR_I != ADDR_CTRL
      && ADR_I != ADDR_STATUS && ADR_I != ADDR_IRQ |-> DAT_O == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_switch_follow: assert property (
      calm && sw_q && ov_q && APP_SUPPLY_ON_THRESH_I && CHARGER_INPUT_I
      && THERMISTOR_IN_RANGE_I && !DIE_COLD_I |-> BATT_SWITCH_O == ct_q)
      else $error("switch ignores control bit");
   a_drop_closes: assert property (
      calm && sw_q && ov_q && !APP_SUPPLY_ON_THRESH_I && BATT_MIN_THRESH_I
      |-> BATT_SWITCH_O) else $error("switch open after supply drop");
   a_gpo_auto: assert property (
      calm && CHARGER_INPUT_I && CORE_READY_I && !td_q |-> GP_OUTPUT_ONE_O)
      else $error("output one not driven");
   a_gpo_inhibit: assert property (
      calm && td_q |-> GP_OUTPUT_ONE_O == ge_q)
      else $error("output one ignores enable");
   a_cold_pause: assert property (
      calm && DIE_COLD_I && !sw_q |-> !CHARGE_TIMER_EN_O && !PRECHARGE_TIMER_EN_O)
      else $error("timers run with cold die");
endmodule
bind cbc_top cbc_top_props u_props (.*);
`default_nettype wire
